// ---- acs_pkg.sv ----
// Shared constants and types for the channel sequence loader
package acs_pkg;

  localparam int unsigned ACS_NIB_W = 4;
  localparam int unsigned ACS_MAX_ENTRIES = 256;
  localparam int unsigned ACS_PTR_W = 8;
  localparam int unsigned ACS_CNT_W = 9;
  localparam int unsigned ACS_LEN_FRAME_BITS = 8;
  localparam int unsigned ACS_MASK_W = 16;
  localparam int unsigned ACS_PAIRS = 8;
  localparam logic [3:0] ACS_ANALOG_INPUT_ZERO = 4'h0;
  localparam logic [1:0] ACS_NIB_LAST_BIT = 2'h3;
  localparam logic [2:0] ACS_LEN_LAST_BIT = 3'h7;
  localparam logic ACS_CS_IDLE = 1'b1;
  localparam logic ACS_SCLK_IDLE = 1'b0;

  // Operating mode chosen by the scan-control setting
  typedef enum logic [3:0] {
    ACS_MODE_MANUAL,
    ACS_MODE_REPEAT,
    ACS_MODE_ORDERED_SCAN_EXTERNAL_CLOCK,
    ACS_MODE_ORDERED_SCAN_INTERNAL_CLOCK,
    ACS_MODE_TOP_SCAN_EXTERNAL_CLOCK,
    ACS_MODE_TOP_SCAN_INTERNAL_CLOCK,
    ACS_MODE_MASK_SCAN_EXTERNAL_CLOCK,
    ACS_MODE_MASK_SCAN_INTERNAL_CLOCK,
    ACS_MODE_PROGRAMMABLE_CHANNEL_SEQUENCE
  } acs_mode_t;

endpackage : acs_pkg

// ---- acs_sync3.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module acs_sync3 #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pin and filtered level
  input wire logic pin,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s2_q;
      end
    end
  end

endmodule : acs_sync3

// ---- acs_loader.sv ----
// Channel sequence loader: serial pattern capture, activation and channel selection
//
// Summary of operation
// - Single select drives manual, repeat, ordered and top scans; mask drives mask scans.
// - Scan mode picks operation; bipolar settings pick coding, differential settings pick input type.
// - Inputs pair as even/odd; every pair behaves like inputs zero and one.
// - A sequence length register defines how many entries the sequence holds.
// - Up to 256 entries, each single-ended or differential, in any order.
// - Entries arrive as consecutive 4-bit nibbles and are decoded in order.
// - New pattern becomes active at the next chip-select falling edge.
// - Entries missing from a short pattern default to analog input zero.
// - Nibbles beyond the programmed length are discarded until chip select rises.
// - A nibble cut by chip select is stored as analog input zero.
// - Conversions start at the first entry once the host starts the sequence.
// - Automatic shutdown may be requested while the last result is read.
`timescale 1ns/10ps
module acs_loader (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic din,
  // Configuration
  input wire acs_pkg::acs_mode_t scan_mode,
  input wire logic [3:0] single_channel_select,
  input wire logic [15:0] scan_channel_mask,
  input wire logic [7:0] pair_differential,
  input wire logic [7:0] pair_bipolar,
  input wire logic seq_load_arm,
  // Conversion control
  input wire logic seq_run,
  input wire logic conv_done,
  input wire logic shutdown_req,
  // Status and channel outputs
  output logic [3:0] conv_channel_q,
  output logic conv_diff_q,
  output logic conv_bipolar_q,
  output logic last_entry_q,
  output logic automatic_shutdown_q,
  output logic seq_pending_q,
  output logic [8:0] sequence_entry_count_q
);
  import acs_pkg::*;

  typedef enum logic [1:0] {ACS_ST_IDLE, ACS_ST_LEN, ACS_ST_PAT_WAIT, ACS_ST_PAT} acs_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic cs_d1_q;
  logic sclk_d1_q;

  acs_sync3 #(.INIT(ACS_CS_IDLE)) u_sync_cs (
    .core_clk(core_clk), .rst_b(rst_b), .pin(cs_b), .level_q(cs_s));
  acs_sync3 #(.INIT(ACS_SCLK_IDLE)) u_sync_sclk (
    .core_clk(core_clk), .rst_b(rst_b), .pin(sclk), .level_q(sclk_s));
  acs_sync3 #(.INIT(1'b0)) u_sync_din (
    .core_clk(core_clk), .rst_b(rst_b), .pin(din), .level_q(din_s));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_d1_q <= ACS_CS_IDLE;
      sclk_d1_q <= ACS_SCLK_IDLE;
    end else begin
      cs_d1_q <= cs_s;
      sclk_d1_q <= sclk_s;
    end
  end

  wire cs_fall = cs_d1_q & ~cs_s;
  wire cs_rise = ~cs_d1_q & cs_s;
  // Data is taken on rising sclk only inside a frame
  wire bit_tick = ~sclk_d1_q & sclk_s & ~cs_s;

  ////////////////////////////////////////////////////////////////////////////
  // Frame parser
  acs_state_t st_q;
  acs_state_t st_d;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic len_done_q;
  logic [8:0] len_q;
  logic [8:0] wr_cnt_q;
  logic [3:0] mem [0:511];
  logic wr_bank_q;
  logic act_bank_q;
  logic [8:0] act_fill_q;

  wire [7:0] shift_nx = {shift_q[6:0], din_s};
  wire room = wr_cnt_q < len_q;
  wire nib_done = (st_q == ACS_ST_PAT) && bit_tick && (bit_cnt_q[1:0] == ACS_NIB_LAST_BIT);
  wire nib_cut = (st_q == ACS_ST_PAT) && cs_rise && (bit_cnt_q[1:0] != 2'h0);
  wire wr_en = (nib_done || nib_cut) && room;
  wire [3:0] wr_dat = nib_cut ? ACS_ANALOG_INPUT_ZERO : shift_nx[3:0];
  wire [8:0] wr_addr = {wr_bank_q, wr_cnt_q[7:0]};
  wire len_capture = (st_q == ACS_ST_LEN) && bit_tick && !len_done_q
                     && (bit_cnt_q == ACS_LEN_LAST_BIT);
  wire activate = seq_pending_q && cs_fall;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ACS_ST_IDLE: begin
        if (cs_fall && seq_load_arm) begin
          st_d = ACS_ST_LEN;
        end
      end
      ACS_ST_LEN: begin
        if (cs_rise) begin
          st_d = ACS_ST_PAT_WAIT;
        end
      end
      ACS_ST_PAT_WAIT: begin
        if (cs_fall) begin
          st_d = ACS_ST_PAT;
        end
      end
      ACS_ST_PAT: begin
        if (cs_rise) begin
          st_d = ACS_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ACS_ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      len_done_q <= 1'b0;
      len_q <= 9'h000;
    end else begin
      st_q <= st_d;
      if (cs_fall) begin
        bit_cnt_q <= 3'h0;
        len_done_q <= 1'b0;
      end else if (bit_tick) begin
        shift_q <= shift_nx;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (len_capture) begin
        len_q <= {1'b0, shift_nx} + 9'h001;
        len_done_q <= 1'b1;
      end
    end
  end

  // Surplus nibbles fail the room check and are dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_cnt_q <= 9'h000;
    end else if (st_q == ACS_ST_PAT_WAIT && cs_fall) begin
      wr_cnt_q <= 9'h000;
    end else if (wr_en) begin
      wr_cnt_q <= wr_cnt_q + 9'h001;
    end
  end

  // Two banks keep the running pattern intact while a new one loads
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activation and sequence pointer
  logic [7:0] ptr_q;
  logic [3:0] mask_ptr_q;

  wire rd_beyond = {1'b0, ptr_q} >= act_fill_q;
  wire [3:0] rd_nib = rd_beyond ? ACS_ANALOG_INPUT_ZERO : mem[{act_bank_q, ptr_q}];
  wire is_seq = scan_mode == ACS_MODE_PROGRAMMABLE_CHANNEL_SEQUENCE;
  wire is_mask = (scan_mode == ACS_MODE_MASK_SCAN_EXTERNAL_CLOCK)
                 || (scan_mode == ACS_MODE_MASK_SCAN_INTERNAL_CLOCK);
  wire at_last = ({1'b0, ptr_q} + 9'h001) >= sequence_entry_count_q;
  wire adv = seq_run && conv_done;

  function automatic logic [3:0] next_mask(input logic [15:0] m, input logic [3:0] cur);
    logic [3:0] r;
    logic found;
    logic [3:0] c;
    r = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      c = cur + i[3:0];
      if (!found && m[c]) begin
        r = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction : next_mask

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_pending_q <= 1'b0;
      wr_bank_q <= 1'b1;
      act_bank_q <= 1'b0;
      act_fill_q <= 9'h000;
      sequence_entry_count_q <= 9'h001;
    end else begin
      if (activate) begin
        seq_pending_q <= 1'b0;
        act_bank_q <= wr_bank_q;
        wr_bank_q <= act_bank_q;
        act_fill_q <= wr_cnt_q;
        sequence_entry_count_q <= len_q;
      end else if (st_q == ACS_ST_PAT && cs_rise) begin
        seq_pending_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= 8'h00;
      mask_ptr_q <= 4'h0;
    end else begin
      if (activate || !seq_run) begin
        ptr_q <= 8'h00;
      end else if (adv && is_seq) begin
        ptr_q <= at_last ? 8'h00 : ptr_q + 8'h01;
      end
      if (adv && is_mask) begin
        mask_ptr_q <= next_mask(scan_channel_mask, mask_ptr_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection and outputs
  wire [3:0] raw_ch = is_seq ? rd_nib : (is_mask ? mask_ptr_q : single_channel_select);
  wire [2:0] pair_idx = raw_ch[3:1];
  wire sel_diff = pair_differential[pair_idx];
  wire [3:0] sel_ch = sel_diff ? {raw_ch[3:1], 1'b0} : raw_ch;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_channel_q <= ACS_ANALOG_INPUT_ZERO;
      conv_diff_q <= 1'b0;
      conv_bipolar_q <= 1'b0;
      last_entry_q <= 1'b0;
      automatic_shutdown_q <= 1'b0;
    end else begin
      conv_channel_q <= sel_ch;
      conv_diff_q <= sel_diff;
      conv_bipolar_q <= pair_bipolar[pair_idx];
      last_entry_q <= seq_run && is_seq && at_last;
      if (shutdown_req && last_entry_q) begin
        automatic_shutdown_q <= 1'b1;
      end else if (cs_fall) begin
        automatic_shutdown_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking acs_cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_activate_on_fall: assert property (activate |=> !seq_pending_q && $changed(act_bank_q))
    else $error("pending pattern not activated at cs fall");
  a_start_first_entry: assert property (activate |=> ptr_q == 8'h00)
    else $error("sequence does not restart at first entry");
  a_pointer_wraps: assert property (adv && is_seq && at_last && !activate |=> ptr_q == 8'h00)
    else $error("pointer did not wrap after last entry");
  a_surplus_dropped: assert property (nib_done && !room |=> $stable(wr_cnt_q))
    else $error("surplus nibble was counted");
  a_cut_nibble_zero: assert property (nib_cut && room |-> wr_en ##1 mem[$past(wr_addr)] == 4'h0)
    else $error("cut nibble not stored as input zero");
  a_fill_short: assert property (is_seq && rd_beyond |=> conv_channel_q == 4'h0)
    else $error("missing entry not input zero");
  a_len_capture: assert property (len_capture |=> len_q == {1'b0, $past(shift_nx)} + 9'h001)
    else $error("length not captured");
  a_len_bound: assert property (wr_cnt_q <= 9'h100 && len_q <= 9'h100)
    else $error("entry count exceeds 256");
  a_write_order: assert property (wr_en |=> wr_cnt_q == $past(wr_cnt_q) + 9'h001)
    else $error("nibbles not stored in order");
  a_manual_select: assert property (scan_mode == ACS_MODE_MANUAL && !sel_diff
                                    |=> conv_channel_q == $past(single_channel_select))
    else $error("manual mode ignores single select");
  a_pair_even: assert property (conv_diff_q |-> conv_channel_q[0] == 1'b0)
    else $error("differential channel not even");
  a_coding_follow: assert property (##1 conv_bipolar_q == $past(pair_bipolar[pair_idx]))
    else $error("coding does not follow bipolar setting");
  a_shutdown_set: assert property (shutdown_req && last_entry_q |=> automatic_shutdown_q)
    else $error("shutdown request lost on last entry");

  c_pattern_activated: cover property (activate);
  c_surplus_seen: cover property (nib_done && !room);
  c_cut_nibble: cover property (nib_cut && room);
  c_wrap: cover property (adv && is_seq && at_last);

endmodule : acs_loader

// ---- acs_host.sv ----
// Host-side serial model that sends chip-select frames, bits MSB first
`timescale 1ns/10ps
module acs_host (
  // Serial link pins
  output logic cs_b,
  output logic sclk,
  output logic din
);
  localparam time HALF = 80ns;
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One frame of n bits; a count that is not a multiple of four cuts the last nibble
  task automatic frame(input logic [31:0] bits, input int n);
    // Pins move 1 ns off the core clock edge, so a change never races the sampling
    #1;
    cs_b = 1'b0;
    #HALF;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      #HALF;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    cs_b = 1'b1;
    // Released line flips so a stale bit can never pass for data
    din = ~din;
    #(4 * HALF - 1ns);
  endtask : frame
endmodule : acs_host

// ---- acs_loader_tb.sv ----
// Self-checking bench for the channel sequence loader
`timescale 1ns/10ps
module acs_loader_tb;
  import acs_pkg::*;
  typedef struct {
    acs_mode_t m;
    logic [3:0] sel;
    logic [15:0] mask;
    logic [7:0] dif;
    logic [7:0] bip;
    logic [3:0] ch;
    logic d;
    logic b;
  } acs_row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_b;
  logic sclk;
  logic din;
  acs_mode_t scan_mode = ACS_MODE_MANUAL;
  logic [3:0] single_channel_select = 4'h0;
  logic [15:0] scan_channel_mask = 16'h0000;
  logic [7:0] pair_differential = 8'h00;
  logic [7:0] pair_bipolar = 8'h00;
  logic seq_load_arm = 1'b0;
  logic seq_run = 1'b0;
  logic conv_done = 1'b0;
  logic shutdown_req = 1'b0;
  logic [3:0] conv_channel_q;
  logic conv_diff_q;
  logic conv_bipolar_q;
  logic last_entry_q;
  logic automatic_shutdown_q;
  logic seq_pending_q;
  logic [8:0] sequence_entry_count_q;
  int bad_count = 0;
  int samples_checked = 0;
  acs_row_t rows [8];
  always #2 core_clk = ~core_clk;
  acs_host host_u (.cs_b(cs_b), .sclk(sclk), .din(din));
  acs_loader dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .din(din),
    .scan_mode(scan_mode), .single_channel_select(single_channel_select),
    .scan_channel_mask(scan_channel_mask), .pair_differential(pair_differential),
    .pair_bipolar(pair_bipolar), .seq_load_arm(seq_load_arm), .seq_run(seq_run),
    .conv_done(conv_done), .shutdown_req(shutdown_req), .conv_channel_q(conv_channel_q),
    .conv_diff_q(conv_diff_q), .conv_bipolar_q(conv_bipolar_q), .last_entry_q(last_entry_q),
    .automatic_shutdown_q(automatic_shutdown_q), .seq_pending_q(seq_pending_q),
    .sequence_entry_count_q(sequence_entry_count_q)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // One-cycle pulse, then enough cycles for pointer and output register to follow
  task automatic pulse_done;
    tick(1);
    conv_done <= 1'b1;
    tick(1);
    conv_done <= 1'b0;
    tick(4);
    @(negedge core_clk);
  endtask : pulse_done
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // The frames take about 8.3 us in all
  initial begin
    #100us;
    bad_count++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{ACS_MODE_MANUAL, 4'h5, 16'h0000, 8'h00, 8'h00, 4'h5, 1'b0, 1'b0};
    rows[1] = '{ACS_MODE_REPEAT, 4'h5, 16'h0000, 8'h04, 8'h04, 4'h4, 1'b1, 1'b1};
    rows[2] = '{ACS_MODE_ORDERED_SCAN_EXTERNAL_CLOCK, 4'hB, 16'h0000, 8'h00, 8'h20, 4'hB, 1'b0, 1'b1};
    rows[3] = '{ACS_MODE_ORDERED_SCAN_INTERNAL_CLOCK, 4'h1, 16'hFFFF, 8'h00, 8'h00, 4'h1, 1'b0, 1'b0};
    rows[4] = '{ACS_MODE_TOP_SCAN_EXTERNAL_CLOCK, 4'hE, 16'h0000, 8'h80, 8'h00, 4'hE, 1'b1, 1'b0};
    rows[5] = '{ACS_MODE_TOP_SCAN_INTERNAL_CLOCK, 4'h7, 16'h0001, 8'h00, 8'h08, 4'h7, 1'b0, 1'b1};
    rows[6] = '{ACS_MODE_MASK_SCAN_EXTERNAL_CLOCK, 4'h5, 16'h0008, 8'h00, 8'h00, 4'h3, 1'b0, 1'b0};
    rows[7] = '{ACS_MODE_MASK_SCAN_INTERNAL_CLOCK, 4'h5, 16'h0400, 8'h20, 8'h00, 4'hA, 1'b1, 1'b0};
    tick(2);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk("count at reset", 9'h001, sequence_entry_count_q);
    chk("pending at reset", 9'h000, 9'(seq_pending_q));
    chk("shutdown at reset", 9'h000, 9'(automatic_shutdown_q));
    tick(1);
    seq_run <= 1'b1;
    foreach (rows[i]) begin
      tick(1);
      scan_mode <= rows[i].m;
      single_channel_select <= rows[i].sel;
      scan_channel_mask <= rows[i].mask;
      pair_differential <= rows[i].dif;
      pair_bipolar <= rows[i].bip;
      pulse_done();
      pulse_done();
      chk("mode channel", 9'(rows[i].ch), 9'(conv_channel_q));
      chk("mode diff", 9'(rows[i].d), 9'(conv_diff_q));
      chk("mode bipolar", 9'(rows[i].b), 9'(conv_bipolar_q));
    end
    // Length 4, pattern 9, 2, then a nibble cut after two bits
    tick(1);
    seq_run <= 1'b0;
    scan_mode <= ACS_MODE_PROGRAMMABLE_CHANNEL_SEQUENCE;
    pair_differential <= 8'h00;
    pair_bipolar <= 8'h00;
    seq_load_arm <= 1'b1;
    host_u.frame(32'h00000003, 8);
    tick(1);
    seq_load_arm <= 1'b0;
    host_u.frame(32'h0000024B, 10);
    @(negedge core_clk);
    chk("pending", 9'h001, 9'(seq_pending_q));
    chk("count kept", 9'h001, sequence_entry_count_q);
    host_u.frame(32'h00000000, 0);
    @(negedge core_clk);
    chk("pending cleared", 9'h000, 9'(seq_pending_q));
    chk("count", 9'h004, sequence_entry_count_q);
    chk("first entry", 9'h009, 9'(conv_channel_q));
    chk("not last", 9'h000, 9'(last_entry_q));
    tick(1);
    seq_run <= 1'b1;
    pulse_done();
    chk("entry one", 9'h002, 9'(conv_channel_q));
    pulse_done();
    chk("cut nibble", 9'h000, 9'(conv_channel_q));
    pulse_done();
    chk("missing entry", 9'h000, 9'(conv_channel_q));
    chk("last entry", 9'h001, 9'(last_entry_q));
    tick(1);
    shutdown_req <= 1'b1;
    tick(1);
    shutdown_req <= 1'b0;
    tick(2);
    @(negedge core_clk);
    chk("shutdown", 9'h001, 9'(automatic_shutdown_q));
    pulse_done();
    chk("wrap", 9'h009, 9'(conv_channel_q));
    // Reload with length 1 and two nibbles; the second must be dropped
    tick(1);
    seq_load_arm <= 1'b1;
    host_u.frame(32'h00000000, 8);
    tick(1);
    seq_load_arm <= 1'b0;
    host_u.frame(32'h00000075, 8);
    host_u.frame(32'h00000000, 0);
    @(negedge core_clk);
    chk("new count", 9'h001, sequence_entry_count_q);
    chk("shutdown cleared", 9'h000, 9'(automatic_shutdown_q));
    chk("kept entry", 9'h007, 9'(conv_channel_q));
    pulse_done();
    chk("surplus dropped", 9'h007, 9'(conv_channel_q));
    // Reset in mid-run drops the active pattern, so every entry reads input zero
    tick(1);
    rst_b <= 1'b0;
    tick(2);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk("count after reset", 9'h001, sequence_entry_count_q);
    chk("pending after reset", 9'h000, 9'(seq_pending_q));
    chk("channel after reset", 9'h000, 9'(conv_channel_q));
    pulse_done();
    chk("entry after reset", 9'h000, 9'(conv_channel_q));
    end_sim();
  end
endmodule : acs_loader_tb
